// File: inc/lock_sync_pkg.sv
// shared constants and types of the input lock and sync monitor
package lock_sync_pkg;
  // ************************************************************
  // clock and input ranges
  // ************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PW = 11;
  localparam int unsigned NUM_IN = 6;
  localparam int unsigned MADI_MIN_HZ = 25000;
  localparam int unsigned MADI_MAX_HZ = 54000;
  localparam int unsigned WIDE_MIN_HZ = 27000;
  localparam int unsigned WIDE_MAX_HZ = 200000;
  localparam int unsigned OPT8_MIN_HZ = 31500;
  localparam int unsigned OPT8_MAX_HZ = 50000;
  localparam int unsigned INT_MIN_HZ = 28000;
  localparam int unsigned INT_MAX_HZ = 200000;
  localparam int unsigned INT_RST_HZ = 48000;
  localparam int unsigned DBL_HZ = 54000;
  localparam int unsigned QUAD_HZ = 108000;
  // periods in clock cycles: shortest from highest rate, longest from lowest
  localparam logic [PW-1:0] MADI_MIN_P = PW'(CLK_HZ / MADI_MAX_HZ);
  localparam logic [PW-1:0] MADI_MAX_P = PW'(CLK_HZ / MADI_MIN_HZ);
  localparam logic [PW-1:0] WIDE_MIN_P = PW'(CLK_HZ / WIDE_MAX_HZ);
  localparam logic [PW-1:0] WIDE_MAX_P = PW'(CLK_HZ / WIDE_MIN_HZ);
  localparam logic [PW-1:0] OPT8_MIN_P = PW'(CLK_HZ / OPT8_MAX_HZ);
  localparam logic [PW-1:0] OPT8_MAX_P = PW'(CLK_HZ / OPT8_MIN_HZ);
  localparam logic [PW-1:0] INT_MIN_P = PW'(CLK_HZ / INT_MAX_HZ);
  localparam logic [PW-1:0] INT_MAX_P = PW'(CLK_HZ / INT_MIN_HZ);
  localparam logic [PW-1:0] INT_PERIOD_RST = PW'(CLK_HZ / INT_RST_HZ);
  localparam logic [PW-1:0] DBL_P = PW'(CLK_HZ / DBL_HZ);
  localparam logic [PW-1:0] QUAD_P = PW'(CLK_HZ / QUAD_HZ);
  localparam logic [PW-1:0] DRIFT_CYC = 11'h004;
  localparam logic [3:0] LOCK_GOOD = 4'h8;
  localparam logic [7:0] WINDOW_REFS = 8'h40;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INT_PERIOD = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_INFO = 8'h14;
  localparam int unsigned IRQ_W = 14;
  localparam int unsigned IRQ_LOCK_LSB = 0;
  localparam int unsigned IRQ_SYNC_LSB = 6;
  localparam int unsigned IRQ_REJECT = 12;
  localparam int unsigned IRQ_REF_FAULT = 13;
  localparam int unsigned IN_MADI = 0;
  localparam int unsigned IN_AES = 1;
  localparam int unsigned IN_OPT1 = 2;
  localparam int unsigned IN_OPT2 = 3;
  localparam int unsigned IN_SPDIF = 4;
  localparam int unsigned IN_WCK = 5;
  localparam logic [6:0] CH_56 = 7'h38;
  localparam logic [6:0] CH_64 = 7'h40;
  localparam logic [6:0] CH_HIGH = 7'h20;
  localparam logic [6:0] CH_QUAD = 7'h10;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    REF_INTERNAL = 3'b000, REF_OPT8 = 3'b001, REF_AES = 3'b010, REF_MADI = 3'b011, REF_WORD = 3'b100
  } ref_src_t;
  typedef enum logic [1:0] {ST_NO_LOCK = 2'b00, ST_LOCK = 2'b01, ST_SYNC = 2'b10} clock_state_t;
  typedef enum logic [1:0] {FRAME_56CH = 2'b00, FRAME_64CH = 2'b01, FRAME_HIGH_RATE = 2'b10} madi_frame_t;
  typedef enum logic [1:0] {
    SPLIT_NONE = 2'b00, DOUBLE_RATE_CHANNEL_SPLIT = 2'b01, QUAD_RATE_CHANNEL_SPLIT = 2'b10
  } channel_split_t;
  typedef struct packed {
    logic frame_tick;
    logic locked;
    logic synced;
  } chan_stat_t;
endpackage

// File: hw/input_channel_monitor.sv
// lock and synchronism tracker for one incoming frame clock
`timescale 1ns/1ps
`default_nettype none
module input_channel_monitor #(
  parameter logic [10:0] MIN_P = 11'h07D,
  parameter logic [10:0] MAX_P = 11'h39D,
  parameter bit AUTO_DIV = 1'b0
) (
  // clock, reset and enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // frame clock from the receiver and reference tick
  input wire logic frame_in,
  input wire logic ref_tick_in,
  // status
  output var lock_sync_pkg::chan_stat_t stat_out,
  output logic [1:0] rate_mult_out
);
  import lock_sync_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [PW-1:0] cnt;
    logic [PW-1:0] last;
    logic [3:0] good;
    logic locked;
    logic [1:0] mult;
    logic [1:0] div;
    logic tick;
    logic [7:0] rcnt;
    logic [7:0] ecnt;
    logic synced;
  } chan_state_t;

  chan_state_t s, next_s;
  logic rise, in_range, near, fire;
  logic [PW-1:0] diff;
  logic [7:0] total;

  // ************************************************************
  // period tracking and synchronism window
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.s1 = frame_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.tick = 1'b0;
    if (s.s2 == s.s3) begin
      next_s.lvl = s.s3;
    end
    rise = s.s2 & s.s3 & ~s.lvl;
    in_range = (s.cnt >= MIN_P) && (s.cnt <= MAX_P);
    diff = (s.cnt > s.last) ? s.cnt - s.last : s.last - s.cnt;
    near = diff <= DRIFT_CYC;
    fire = 1'b0;
    if (rise) begin
      next_s.cnt = PW'(1);
      next_s.last = s.cnt;
      if (in_range && near) begin
        if (s.good != LOCK_GOOD) begin
          next_s.good = s.good + 4'h1;
        end
      end else begin
        next_s.good = 4'h0;
      end
      next_s.locked = in_range && near && (s.good >= LOCK_GOOD - 4'h1);
      if (AUTO_DIV && in_range) begin
        next_s.mult = (s.cnt < QUAD_P) ? 2'h2 : ((s.cnt < DBL_P) ? 2'h1 : 2'h0);
      end
      next_s.div = s.div + 2'h1;
      case (s.mult)
        2'h2: fire = (s.div == 2'h0);
        2'h1: fire = ~s.div[0];
        default: fire = 1'b1;
      endcase
      next_s.tick = fire && next_s.locked;
    end else if (s.cnt > MAX_P) begin
      // carrier gone: drop lock rather than wait for an edge that may never come
      next_s.locked = 1'b0;
      next_s.good = 4'h0;
    end else begin
      next_s.cnt = s.cnt + PW'(1);
    end
    total = (s.ecnt == 8'hFF) ? 8'hFF : s.ecnt + {7'h00, s.tick};
    next_s.ecnt = total;
    if (ref_tick_in) begin
      if (s.rcnt == WINDOW_REFS - 8'h01) begin
        next_s.synced = s.locked && (total == WINDOW_REFS);
        next_s.rcnt = 8'h00;
        next_s.ecnt = 8'h00;
      end else begin
        next_s.rcnt = s.rcnt + 8'h01;
      end
    end
    if (!next_s.locked) begin
      next_s.synced = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign stat_out = '{frame_tick: s.tick, locked: s.locked, synced: s.synced};
  assign rate_mult_out = s.mult;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in || !ce_in);

  property p_lock_timeout;
    (s.cnt > MAX_P) |=> !s.locked;
  endproperty
  a_lock_timeout: assert property (p_lock_timeout) else $error("lock held with no carrier");

  property p_short_period;
    (rise && (s.cnt < MIN_P)) |=> !s.locked;
  endproperty
  a_short_period: assert property (p_short_period) else $error("lock kept above rate range");

  property p_lock_needs_run;
    $rose(s.locked) |-> ($past(s.good) >= LOCK_GOOD - 4'h1);
  endproperty
  a_lock_needs_run: assert property (p_lock_needs_run) else $error("lock without stable periods");

  property p_sync_window;
    $rose(s.synced) |-> ($past(ref_tick_in) && ($past(s.rcnt) == WINDOW_REFS - 8'h01));
  endproperty
  a_sync_window: assert property (p_sync_window) else $error("sync set outside window end");

  property p_sync_lock;
    s.synced |-> s.locked;
  endproperty
  a_sync_lock: assert property (p_sync_lock) else $error("sync without lock");

  property p_quad_detect;
    (AUTO_DIV && rise && in_range && (s.cnt < QUAD_P)) |=> (s.mult == 2'h2);
  endproperty
  a_quad_detect: assert property (p_quad_detect) else $error("quad rate not detected");
endmodule // input_channel_monitor
`default_nettype wire

// File: hw/input_lock_sync_monitor.sv
// input lock and synchronism monitor with indicators and wishbone registers
// Notes on behaviour
// - receiver counts as locked once periods match, and stays locked through small drift
// - a locked optical or coaxial stream makes its indicator flash
// - an input locked but not synchronous with the reference keeps flashing
// - inputs synchronous with the reference show a steady indicator
// - software reads each input as no lock, lock or sync
// - master mode runs on internal clock; follow mode takes the selected input
// - reference is internal, eight-channel optical, coaxial, multichannel or word clock
// - internal rate only between 28 kHz and 200 kHz; other values rejected
// - multichannel receiver locks only from 25 kHz to 54 kHz
// - coaxial and optical coaxial-format receivers lock from 27 kHz to 200 kHz
// - eight-channel optical receivers lock from 31.5 to 50 kHz, following varispeed
// - word clock locks 27-200 kHz, double and quad rate divided to single
// - multichannel frame modes 56, 64 and high-rate; 56, 64 or 32 channels without a split
`timescale 1ns/1ps
`default_nettype none
module input_lock_sync_monitor #(
  parameter int unsigned FLASH_CYCLES = lock_sync_pkg::FLASH_CYC
) (
  // clock, reset and enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // receivers
  input wire logic [5:0] frame_in,
  input wire lock_sync_pkg::madi_frame_t madi_frame_mode_in,
  // indicators, reference and interrupt
  output logic [5:0] sync_indicator_out,
  output logic sample_tick_out,
  output logic [6:0] madi_channels_out,
  output logic irq_out
);
  import lock_sync_pkg::*;

  typedef struct packed {
    logic follow_input_clock_mode;
    ref_src_t ref_sel;
    channel_split_t split;
    logic [PW-1:0] int_period;
    logic [PW-1:0] int_cnt;
    logic int_tick;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] rdata;
    logic [22:0] flash_cnt;
    logic flash;
    logic [NUM_IN-1:0] prev_lock;
    logic [NUM_IN-1:0] prev_sync;
    logic [NUM_IN-1:0] ind;
    logic out_tick;
    logic prev_fault;
    logic [6:0] madi_ch;
  } mon_state_t;

  mon_state_t s, next_s;
  chan_stat_t stat [NUM_IN];
  logic [1:0] mult [NUM_IN];
  logic [NUM_IN-1:0] locks, syncs;
  logic [2*NUM_IN-1:0] states;
  logic [IRQ_W-1:0] events, clr;
  logic [31:0] wval, ctrl_word;
  logic hit, follow_ok, ref_tick, fault;
  int unsigned ridx;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic clock_state_t clk_state(input chan_stat_t c);
    if (!c.locked) begin
      return ST_NO_LOCK;
    end else if (c.synced) begin
      return ST_SYNC;
    end
    return ST_LOCK;
  endfunction

  function automatic int unsigned ref_index(input ref_src_t r);
    case (r)
      REF_OPT8: return IN_OPT1;
      REF_AES: return IN_AES;
      REF_WORD: return IN_WCK;
      default: return IN_MADI;
    endcase
  endfunction

  function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // one tracker per input
  // ************************************************************
  for (genvar i = 0; i < NUM_IN; i++) begin : g_chan
    localparam logic [PW-1:0] LO = (i == IN_MADI) ? MADI_MIN_P :
                                   (((i == IN_OPT1) || (i == IN_OPT2)) ? OPT8_MIN_P : WIDE_MIN_P);
    localparam logic [PW-1:0] HI = (i == IN_MADI) ? MADI_MAX_P :
                                   (((i == IN_OPT1) || (i == IN_OPT2)) ? OPT8_MAX_P : WIDE_MAX_P);
    // ranges per receiver type; only the word clock divides double and quad rates
    input_channel_monitor #(
      .MIN_P(LO),
      .MAX_P(HI),
      .AUTO_DIV(i == IN_WCK)
    ) u_chan (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .frame_in(frame_in[i]),
      .ref_tick_in(ref_tick),
      .stat_out(stat[i]),
      .rate_mult_out(mult[i])
    );
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_s = s;
    for (int k = 0; k < NUM_IN; k++) begin
      locks[k] = stat[k].locked;
      syncs[k] = stat[k].synced;
      states[2*k +: 2] = clk_state(stat[k]);
    end
    ridx = ref_index(s.ref_sel);
    follow_ok = s.follow_input_clock_mode && (s.ref_sel != REF_INTERNAL) && locks[ridx];
    // internal divider keeps running in follow mode so a fallback needs no restart
    next_s.int_tick = 1'b0;
    if (s.int_cnt >= s.int_period - PW'(1)) begin
      next_s.int_cnt = '0;
      next_s.int_tick = 1'b1;
    end else begin
      next_s.int_cnt = s.int_cnt + PW'(1);
    end
    ref_tick = follow_ok ? stat[ridx].frame_tick : s.int_tick;
    next_s.out_tick = ref_tick;
    if (s.flash_cnt >= 23'(FLASH_CYCLES - 1)) begin
      next_s.flash_cnt = 23'h000000;
      next_s.flash = ~s.flash;
    end else begin
      next_s.flash_cnt = s.flash_cnt + 23'h000001;
    end
    for (int k = 0; k < NUM_IN; k++) begin
      unique case (clk_state(stat[k]))
        ST_SYNC: next_s.ind[k] = 1'b1;
        ST_LOCK: next_s.ind[k] = s.flash;
        ST_NO_LOCK: next_s.ind[k] = 1'b0;
        default: next_s.ind[k] = 1'b0;
      endcase
    end
    case (madi_frame_mode_in)
      FRAME_HIGH_RATE: next_s.madi_ch = (s.split == QUAD_RATE_CHANNEL_SPLIT) ? CH_QUAD : CH_HIGH;
      FRAME_56CH: next_s.madi_ch = CH_56 >> s.split;
      default: next_s.madi_ch = CH_64 >> s.split;
    endcase
    fault = s.follow_input_clock_mode && (s.ref_sel != REF_INTERNAL) && !follow_ok;
    events = '0;
    events[IRQ_LOCK_LSB +: NUM_IN] = locks ^ s.prev_lock;
    events[IRQ_SYNC_LSB +: NUM_IN] = syncs ^ s.prev_sync;
    events[IRQ_REF_FAULT] = fault && !s.prev_fault;
    next_s.prev_lock = locks;
    next_s.prev_sync = syncs;
    next_s.prev_fault = fault;
    // wishbone: one wait state, ack for a single cycle
    ctrl_word = {26'h0000000, s.split, s.ref_sel, s.follow_input_clock_mode};
    hit = wb_cyc_in && wb_stb_in && !s.ack;
    next_s.ack = hit;
    clr = '0;
    wval = 32'h00000000;
    if (hit && wb_we_in) begin
      case (wb_adr_in)
        REG_CTRL: begin
          wval = merge32(ctrl_word, wb_dat_in, wb_sel_in);
          next_s.follow_input_clock_mode = wval[0];
          next_s.ref_sel = (wval[3:1] > 3'h4) ? REF_INTERNAL : ref_src_t'(wval[3:1]);
          next_s.split = (wval[5:4] == 2'h3) ? SPLIT_NONE : channel_split_t'(wval[5:4]);
        end
        REG_INT_PERIOD: begin
          wval = merge32({21'h000000, s.int_period}, wb_dat_in, wb_sel_in);
          if ((wval >= 32'(INT_MIN_P)) && (wval <= 32'(INT_MAX_P))) begin
            next_s.int_period = wval[PW-1:0];
          end else begin
            events[IRQ_REJECT] = 1'b1;
          end
        end
        REG_IRQ_STATUS: begin
          wval = merge32(32'h00000000, wb_dat_in, wb_sel_in);
          clr = wval[IRQ_W-1:0];
        end
        REG_IRQ_MASK: begin
          wval = merge32({18'h00000, s.irq_mask}, wb_dat_in, wb_sel_in);
          next_s.irq_mask = wval[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    next_s.rdata = 32'h00000000;
    if (hit && !wb_we_in) begin
      case (wb_adr_in)
        REG_CTRL: next_s.rdata = ctrl_word;
        REG_INT_PERIOD: next_s.rdata = {21'h000000, s.int_period};
        REG_STATE: next_s.rdata = {20'h00000, states};
        REG_IRQ_STATUS: next_s.rdata = {18'h00000, s.irq_status};
        REG_IRQ_MASK: next_s.rdata = {18'h00000, s.irq_mask};
        REG_INFO: next_s.rdata = {17'h00000, s.madi_ch, 5'h00, mult[IN_WCK], follow_ok};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~clr) | events;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.int_period <= INT_PERIOD_RST;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign wb_dat_out = s.rdata;
  assign wb_ack_out = s.ack;
  assign sync_indicator_out = s.ind;
  assign sample_tick_out = s.out_tick;
  assign madi_channels_out = s.madi_ch;
  assign irq_out = s.irq;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in || !ce_in);

  property p_ack_after_req;
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("no ack one cycle after request");

  property p_ack_single;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

  property p_steady;
    stat[IN_AES].synced |=> sync_indicator_out[IN_AES];
  endproperty
  a_steady: assert property (p_steady) else $error("synchronous input not steady");

  property p_flash;
    (stat[IN_OPT1].locked && !stat[IN_OPT1].synced) |=> (sync_indicator_out[IN_OPT1] == $past(s.flash));
  endproperty
  a_flash: assert property (p_flash) else $error("locked input not flashing");

  property p_dark;
    !stat[IN_MADI].locked |=> !sync_indicator_out[IN_MADI];
  endproperty
  a_dark: assert property (p_dark) else $error("unlocked input indicator lit");

  property p_rate_reject;
    (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && (wb_adr_in == REG_INT_PERIOD) &&
     (wb_sel_in == 4'hF) && ((wb_dat_in < 32'(INT_MIN_P)) || (wb_dat_in > 32'(INT_MAX_P)))) |=>
    ($stable(s.int_period) && s.irq_status[IRQ_REJECT]);
  endproperty
  a_rate_reject: assert property (p_rate_reject) else $error("out of span rate accepted");

  property p_master_tick;
    (!s.follow_input_clock_mode && s.int_tick) |=> sample_tick_out;
  endproperty
  a_master_tick: assert property (p_master_tick) else $error("master mode not on internal clock");

  property p_follow_tick;
    (follow_ok && stat[ridx].frame_tick) |=> sample_tick_out;
  endproperty
  a_follow_tick: assert property (p_follow_tick) else $error("selected input not followed");

  property p_madi_quad;
    ((madi_frame_mode_in == FRAME_64CH) && (s.split == QUAD_RATE_CHANNEL_SPLIT)) |=> (madi_channels_out == CH_QUAD);
  endproperty
  a_madi_quad: assert property (p_madi_quad) else $error("quad rate channel count wrong");

  property p_fault_irq;
    (fault && !s.prev_fault) |=> s.irq_status[IRQ_REF_FAULT];
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("reference fault not flagged");

  property p_fallback_tick;
    (s.follow_input_clock_mode && !follow_ok && s.int_tick) |=> sample_tick_out;
  endproperty
  a_fallback_tick: assert property (p_fallback_tick) else $error("no internal tick after fallback");

  property p_event_wins;
    (events != '0) |=> ((s.irq_status & $past(events)) == $past(events));
  endproperty
  a_event_wins: assert property (p_event_wins) else $error("event lost to a clear");

  property p_state_read;
    (hit && !wb_we_in && (wb_adr_in == REG_STATE)) |=> (wb_dat_out == {20'h00000, $past(states)});
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read differs from trackers");

  property p_cov_fault;
    $rose(s.irq_status[IRQ_REF_FAULT]);
  endproperty
  c_cov_fault: cover property (p_cov_fault);

  property p_cov_sync;
    $rose(stat[IN_AES].synced);
  endproperty
  c_cov_sync: cover property (p_cov_sync);

  property p_cov_follow;
    $rose(follow_ok);
  endproperty
  c_cov_follow: cover property (p_cov_follow);

  property p_cov_irq;
    $rose(irq_out);
  endproperty
  c_cov_irq: cover property (p_cov_irq);
endmodule // input_lock_sync_monitor
`default_nettype wire

// File: verification/frame_source.sv
// behavioural source of the six incoming frame clocks
`timescale 1ns/1ps
`default_nettype none
module frame_source (
  // link clock and per-input period in link cycles, zero keeps an input silent
  input wire logic link_clk_in,
  input wire logic [47:0] period_in,
  // frame clocks, high for the first half of each period
  output logic [5:0] frame_out = 6'h00
);
  logic [7:0] cnt [6] = '{default: 8'h00};
  // periods are whole link cycles, so the rate ratio to the bench clock is exact
  always_ff @(posedge link_clk_in) begin
    for (int i = 0; i < 6; i++) begin
      cnt[i] <= (cnt[i] + 8'h01 >= period_in[8*i+:8]) ? 8'h00 : cnt[i] + 8'h01;
      frame_out[i] <= (cnt[i] < (period_in[8*i+:8] >> 1));
    end
  end
endmodule // frame_source
`default_nettype wire

// File: verification/tb.sv
// self-checking testbench of the input lock and sync monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lock_sync_pkg::*;
  // ************************************************************
  // stimulus, design and far side
  // ************************************************************
  logic clock_in, link_clk, rst_n_in, cyc, stb, we;
  logic [7:0] adr;
  logic [31:0] dat, rd, wb_dat_out;
  logic wb_ack_out, tick, irq_out;
  logic [5:0] frame, ind, a;
  logic [6:0] madi_ch;
  logic [47:0] periods;
  madi_frame_t mode;
  int n_mismatch = 0;
  int checks = 0;
  int ticks;
  typedef struct {logic [7:0] adr; madi_frame_t mode; logic [31:0] mask; logic [31:0] exp;} row_t;
  row_t rows [6] = '{
    '{REG_STATE, FRAME_56CH, 32'h00000FFF, 32'h0000092A},
    '{REG_INFO, FRAME_56CH, 32'h00007F00, 32'h00003800},
    '{REG_INFO, FRAME_64CH, 32'h00007F00, 32'h00004000},
    '{REG_INFO, FRAME_HIGH_RATE, 32'h00007F00, 32'h00002000},
    '{REG_INFO, madi_frame_t'(2'b11), 32'h00007F00, 32'h00004000},
    '{8'h18, FRAME_56CH, 32'hFFFFFFFF, 32'h00000000}};
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // link clock phase is unrelated to the bench clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = ~link_clk;
  end
  input_lock_sync_monitor #(.FLASH_CYCLES(16)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .frame_in(frame), .madi_frame_mode_in(mode),
    .sync_indicator_out(ind), .sample_tick_out(tick), .madi_channels_out(madi_ch), .irq_out(irq_out));
  frame_source far_side (.link_clk_in(link_clk), .period_in(periods), .frame_out(frame));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // classic cycle: request held until ack is sampled high, no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    do begin
      @(posedge clock_in);
    end while (wb_ack_out !== 1'b1);
    r = wb_dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3600000;
    n_mismatch++;
    conclude;
  end
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    rst_n_in = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    mode = FRAME_56CH;
    // spdif one link cycle slow, second optical too slow for its span
    periods = {8'd63, 8'd64, 8'd100, 8'd63, 8'd63, 8'd63};
    repeat (12) @(posedge clock_in);
    chk(32'({wb_ack_out, irq_out, ind}), 32'h0);
    rst_n_in <= 1'b1;
    wb(1'b0, REG_INT_PERIOD, 32'h0, rd); chk(rd, 32'h208);
    wb(1'b0, REG_CTRL, 32'h0, rd); chk(rd, 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h1000, rd);
    wb(1'b1, REG_INT_PERIOD, 32'd100, rd);
    repeat (2) @(posedge clock_in);
    chk(32'(irq_out), 32'h1);
    wb(1'b0, REG_INT_PERIOD, 32'h0, rd); chk(rd, 32'h208);
    wb(1'b1, REG_IRQ_STATUS, 32'h1000, rd);
    repeat (2) @(posedge clock_in);
    chk(32'(irq_out), 32'h0);
    wb(1'b1, REG_INT_PERIOD, 32'd504, rd);
    wb(1'b0, REG_INT_PERIOD, 32'h0, rd); chk(rd, 32'd504);
    // lock plus two full windows of 64 reference ticks
    repeat (72000) @(posedge clock_in);
    foreach (rows[i]) begin
      mode <= rows[i].mode;
      repeat (3) @(posedge clock_in);
      wb(1'b0, rows[i].adr, 32'h0, rd); chk(rd & rows[i].mask, rows[i].exp);
      if (rows[i].adr == REG_INFO) chk(32'(madi_ch), 32'(rows[i].exp[14:8]));
    end
    a = ind;
    chk(32'(a & 6'h2F), 32'h27);
    repeat (16) @(posedge clock_in);
    chk(32'(ind[4] ^ a[4]), 32'h1);
    wb(1'b0, REG_IRQ_STATUS, 32'h0, rd); chk(rd & 32'h3F, 32'h37);
    wb(1'b1, REG_CTRL, 32'h0F, rd);
    wb(1'b0, REG_CTRL, 32'h0, rd); chk(rd, 32'h01);
    wb(1'b1, REG_CTRL, 32'h05, rd);
    repeat (3) @(posedge clock_in);
    wb(1'b0, REG_INFO, 32'h0, rd); chk(rd & 32'h1, 32'h1);
    // follow the multichannel input, then silence it; optical 1 too fast; word clock at quad rate
    wb(1'b1, REG_CTRL, 32'h07, rd);
    periods <= {8'd28, 8'd64, 8'd100, 8'd62, 8'd63, 8'd0};
    repeat (3000) @(posedge clock_in);
    wb(1'b0, REG_STATE, 32'h0, rd); chk(rd & 32'h33, 32'h0);
    wb(1'b0, REG_IRQ_STATUS, 32'h0, rd); chk(rd & 32'h2000, 32'h2000);
    wb(1'b0, REG_INFO, 32'h0, rd); chk(rd & 32'h7, 32'h4);
    wb(1'b1, REG_CTRL, 32'h20, rd);
    mode <= FRAME_64CH;
    ticks = 0;
    repeat (2016) begin
      @(posedge clock_in);
      ticks += tick;
    end
    chk(32'(madi_ch), 32'(CH_QUAD));
    chk(ticks, 4);
    // reset in mid-run
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk(32'({wb_ack_out, irq_out, tick, ind, madi_ch}), 32'h0);
    rst_n_in <= 1'b1;
    wb(1'b0, REG_INT_PERIOD, 32'h0, rd); chk(rd, 32'h208);
    conclude;
  end
endmodule // tb
`default_nettype wire
